// ---- include/rcb_consts.svh ----
`ifndef RCB_CONSTS_SVH
`define RCB_CONSTS_SVH
`define RCB_CMD_DOWN_STEP      8'hd9
`define RCB_CMD_TARGET         8'hda
`define RCB_CMD_OFFSET         8'hdb
`define RCB_CMD_STRAP_LO       8'hdc
`define RCB_CMD_STRAP_HI       8'hdd
`define RCB_CMD_BANK           8'hde
`define RCB_CMD_PROT           8'hdf
`define RCB_CMD_UV             8'he1
`define RCB_CMD_PSCOMP         8'he2
`define RCB_CMD_MOD            8'he3
`define RCB_W_DOWN_STEP        14
`define RCB_W_BYTE             8
`define RCB_W_STRAP_LO         5
`define RCB_W_BANK             3
`define RCB_W_PROT             9
`define RCB_W_UV               7
`define RCB_W_PSCOMP           12
`define RCB_W_MOD              14
`define RCB_RST_TARGET         8'h00
`define RCB_RST_OFFSET         8'h00
`define RCB_FIXED_STEP_MV      5
`define RCB_GAIN_SHIFT         5
`define RCB_RETURN_STEP_MV     12'h005
`define RCB_RATE_BASE_CLKS     4
`define RCB_CLK_MHZ            25
`define RCB_UV_DLY0_US         10
`define RCB_UV_DLY1_US         20
`define RCB_UV_DLY2_US         40
`define RCB_UV_DLY3_US         120
`define RCB_UV_TRIP_HYST_MV    9'h013
`define RCB_UNDERVOLTAGE_WARNING_GAP_MV     9'h042
`define RCB_UNDERVOLTAGE_WARNING_HYST_MV    9'h011
`define RCB_PS_STEP_MV         20
`define RCB_CLAMP_STEP_MV      20
`define RCB_DECAY_LO_MV        8'h64
`define RCB_DECAY_HI_MV        8'hc8
`define RCB_BANK_MIRROR0       3'h6
`define RCB_BANK_MIRROR1       3'h7
`define RCB_BANK_ALIAS5        3'h5
`define RCB_PROT_UNDERVOLTAGE_WARNING       8
`define RCB_PROT_UV_TRIP       5
`endif

// ---- include/rcb_pkg.sv ----
package rcb_pkg;
	typedef enum logic [1:0] {
		RCB_PS_FULL,
		RCB_PS_INTER,
		RCB_PS_LIGHT,
		RCB_PS_RSVD
	} rcb_ps_t;
	typedef enum logic [1:0] {
		RCB_DECAY_HALF,
		RCB_DECAY_NORMAL,
		RCB_DECAY_QUARTER
	} rcb_decay_t;
	typedef enum logic [1:0] {
		RCB_LD_IDLE,
		RCB_LD_FETCH,
		RCB_LD_DONE
	} rcb_ld_t;
endpackage : rcb_pkg

// ---- core/rcb_step_return.sv ----
`timescale 1ns/10ps
`include "rcb_consts.svh"
module rcb_step_return
	import rcb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [11:0] load_mv,
	input  wire logic [4:0]  rate_code,
	output logic      [11:0] offset_mv
);
	logic [11:0] offset_r;
	logic [11:0] offset_nxt;
	logic [7:0]  tick_r;
	logic [7:0]  tick_nxt;
	wire  [7:0]  interval = 8'((rate_code + 6'h01) * `RCB_RATE_BASE_CLKS);
	wire         tick_end = (tick_r >= interval - 8'h01);
	wire         at_floor = (offset_r <= `RCB_RETURN_STEP_MV);

	// One step per interval toward zero
	assign tick_nxt   = (load || tick_end || offset_r == 12'h000) ? 8'h00 : tick_r + 8'h01;
	assign offset_nxt = load ? load_mv :
		(tick_end ? (at_floor ? 12'h000 : offset_r - `RCB_RETURN_STEP_MV) : offset_r);
	assign offset_mv  = offset_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			offset_r <= 12'h000;
			tick_r   <= 8'h00;
		end else begin
			offset_r <= offset_nxt;
			tick_r   <= tick_nxt;
		end
	end
endmodule : rcb_step_return

// ---- core/rcb_bank.sv ----
`timescale 1ns/10ps
`include "rcb_consts.svh"
module rcb_bank
	import rcb_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata,
	output logic             cmd_rvalid,
	output logic             cmd_err,
	input  wire logic [2:0]  bank_strap,
	input  wire logic [4:0]  strap_low,
	input  wire logic [7:0]  strap_high,
	input  wire logic [1:0]  bank_overwritten,
	output logic             nvm_fetch_req,
	output logic      [2:0]  memory_bank_select_eff,
	input  wire logic        nvm_ld,
	input  wire logic [7:0]  nvm_ld_code,
	input  wire logic [15:0] nvm_ld_data,
	input  wire logic        nvm_ld_done,
	input  wire logic        dvs_start,
	input  wire logic        dvs_down,
	input  wire logic [11:0] dvs_step_mv,
	output logic      [11:0] down_offset_mv,
	output logic      [7:0]  target_code,
	output logic      [7:0]  offset_code,
	output logic      [8:0]  prot_disable,
	input  wire logic        uv_raw,
	input  wire logic        undervoltage_warning_raw,
	output logic      [8:0]  uv_trip_margin_mv,
	output logic      [8:0]  undervoltage_warning_margin_mv,
	output logic      [8:0]  uv_trip_hyst_mv,
	output logic      [8:0]  undervoltage_warning_hyst_mv,
	output logic             uv_trip,
	output logic             undervoltage_warning,
	output logic             hiccup_req,
	input  wire logic        ps_change,
	input  wire logic [1:0]  ps_from,
	input  wire logic [1:0]  ps_to,
	output logic      [7:0]  ps_offset_mv,
	output logic      [6:0]  comp_clamp_mv,
	output logic      [7:0]  decay_offset_mv,
	input  wire logic [2:0]  phase_count,
	output logic             dead_band_fast,
	output logic      [1:0]  speedup_decay,
	output logic      [2:0]  peak_cap_pf,
	output logic      [2:0]  hp_cap_pf,
	output logic             bal_gain_2x
);
	function automatic logic [7:0] rcb_mv20(input logic [2:0] code);
		rcb_mv20 = 8'(code * `RCB_PS_STEP_MV);
	endfunction : rcb_mv20

	function automatic rcb_decay_t rcb_decay(input logic [1:0] code);
		unique case (code)
			2'h1:    rcb_decay = RCB_DECAY_NORMAL;
			2'h2:    rcb_decay = RCB_DECAY_QUARTER;
			default: rcb_decay = RCB_DECAY_HALF;
		endcase
	endfunction : rcb_decay

	localparam logic [11:0] UV_DLY0 = 12'(`RCB_UV_DLY0_US * `RCB_CLK_MHZ);
	localparam logic [11:0] UV_DLY1 = 12'(`RCB_UV_DLY1_US * `RCB_CLK_MHZ);
	localparam logic [11:0] UV_DLY2 = 12'(`RCB_UV_DLY2_US * `RCB_CLK_MHZ);
	localparam logic [11:0] UV_DLY3 = 12'(`RCB_UV_DLY3_US * `RCB_CLK_MHZ);

	logic [13:0] down_step_r;
	logic [7:0]  target_r;
	logic [7:0]  offset_r;
	logic [4:0]  strap_lo_r;
	logic [7:0]  strap_hi_r;
	logic [2:0]  bank_r;
	logic [8:0]  prot_r;
	logic [6:0]  uv_r;
	logic [11:0] pscomp_r;
	logic [13:0] mod_r;
	logic        strap_take_r;
	rcb_ld_t     ld_r;
	rcb_ld_t     ld_nxt;
	logic [15:0] rdata_r;
	logic        rvalid_r;
	logic        err_r;
	logic [11:0] uv_cnt_r;
	logic [11:0] uv_cnt_nxt;
	logic        uv_trip_r;
	logic        undervoltage_warning_r;
	logic        hiccup_r;
	logic [7:0]  ps_off_r;
	logic [7:0]  ps_off_nxt;

	// Host writes and bank loads share one write path
	wire        loading  = (ld_r == RCB_LD_FETCH);
	wire        wr_host  = cmd_wr && !loading;
	wire        wr_any   = wr_host || (loading && nvm_ld);
	wire [7:0]  wr_code  = wr_host ? cmd_code : nvm_ld_code;
	wire [15:0] wr_data  = wr_host ? cmd_wdata : nvm_ld_data;
	wire        wr_ds    = wr_any && wr_code == `RCB_CMD_DOWN_STEP;
	wire        wr_tgt   = wr_host && cmd_code == `RCB_CMD_TARGET;
	wire        wr_off   = wr_host && cmd_code == `RCB_CMD_OFFSET;
	wire        wr_bank  = wr_host && cmd_code == `RCB_CMD_BANK;
	wire        wr_prot  = wr_any && wr_code == `RCB_CMD_PROT;
	wire        wr_uv    = wr_any && wr_code == `RCB_CMD_UV;
	wire        wr_ps    = wr_any && wr_code == `RCB_CMD_PSCOMP;
	wire        wr_mod   = wr_any && wr_code == `RCB_CMD_MOD;
	wire        wr_known = wr_ds || wr_tgt || wr_off || wr_bank || wr_prot || wr_uv || wr_ps || wr_mod;
	wire        wr_ro    = cmd_code == `RCB_CMD_STRAP_LO || cmd_code == `RCB_CMD_STRAP_HI;

	// Read mux, unused upper bits are zero
	logic [15:0] rd_mux;
	logic        rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		unique case (cmd_code)
			`RCB_CMD_DOWN_STEP: rd_mux = {2'h0, down_step_r};
			`RCB_CMD_TARGET:    rd_mux = {8'h00, target_r};
			`RCB_CMD_OFFSET:    rd_mux = {8'h00, offset_r};
			`RCB_CMD_STRAP_LO:  rd_mux = {11'h000, strap_lo_r};
			`RCB_CMD_STRAP_HI:  rd_mux = {8'h00, strap_hi_r};
			`RCB_CMD_BANK:      rd_mux = {13'h0000, bank_r};
			`RCB_CMD_PROT:      rd_mux = {7'h00, prot_r};
			`RCB_CMD_UV:        rd_mux = {9'h000, uv_r};
			`RCB_CMD_PSCOMP:    rd_mux = {4'h0, pscomp_r};
			`RCB_CMD_MOD:       rd_mux = {2'h0, mod_r};
			default: begin
				rd_mux = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Bank selector and mirror mapping
	assign memory_bank_select_eff = (bank_r == `RCB_BANK_ALIAS5)  ? `RCB_BANK_MIRROR0 :
		(bank_r == `RCB_BANK_MIRROR0 && !bank_overwritten[0]) ? 3'h0 :
		(bank_r == `RCB_BANK_MIRROR1 && !bank_overwritten[1]) ? 3'h1 : bank_r;
	assign nvm_fetch_req = loading;

	// Power-up fetch from selected bank
	always_comb begin
		ld_nxt = ld_r;
		unique case (ld_r)
			RCB_LD_IDLE:  ld_nxt = strap_take_r ? RCB_LD_FETCH : RCB_LD_IDLE;
			RCB_LD_FETCH: ld_nxt = nvm_ld_done ? RCB_LD_DONE : RCB_LD_FETCH;
			RCB_LD_DONE:  ld_nxt = RCB_LD_DONE;
			default:      ld_nxt = RCB_LD_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_take_r <= 1'b1;
			ld_r         <= RCB_LD_IDLE;
		end else begin
			strap_take_r <= 1'b0;
			ld_r         <= ld_nxt;
		end
	end

	// Straps caught on the first edge after reset release
	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_lo_r <= 5'h00;
			strap_hi_r <= 8'h00;
			bank_r     <= 3'h0;
		end else if (strap_take_r) begin
			strap_lo_r <= strap_low;
			strap_hi_r <= strap_high;
			bank_r     <= bank_strap;
		end else if (wr_bank) begin
			bank_r <= wr_data[`RCB_W_BANK-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			target_r <= `RCB_RST_TARGET;
			offset_r <= `RCB_RST_OFFSET;
		end else begin
			if (wr_tgt)
				target_r <= wr_data[`RCB_W_BYTE-1:0];
			if (wr_off)
				offset_r <= wr_data[`RCB_W_BYTE-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			down_step_r <= 14'h0000;
			prot_r      <= 9'h000;
			uv_r        <= 7'h00;
			pscomp_r    <= 12'h000;
			mod_r       <= 14'h0000;
		end else begin
			if (wr_ds)
				down_step_r <= wr_data[`RCB_W_DOWN_STEP-1:0];
			if (wr_prot)
				prot_r <= wr_data[`RCB_W_PROT-1:0];
			if (wr_uv)
				uv_r <= wr_data[`RCB_W_UV-1:0];
			if (wr_ps)
				pscomp_r <= wr_data[`RCB_W_PSCOMP-1:0];
			if (wr_mod)
				mod_r <= wr_data[`RCB_W_MOD-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
			err_r    <= 1'b0;
		end else begin
			rdata_r  <= cmd_rd ? rd_mux : rdata_r;
			rvalid_r <= cmd_rd;
			err_r    <= (cmd_rd && !rd_hit) || (cmd_wr && (loading || (!wr_known && !wr_ro) || wr_ro));
		end
	end

	assign cmd_rdata  = rdata_r;
	assign cmd_rvalid = rvalid_r;
	assign cmd_err    = err_r;
	assign target_code  = target_r;
	assign offset_code  = offset_r;
	assign prot_disable = prot_r;

	// Down-step undershoot: fixed plus proportional part
	wire [8:0]  fixed_mv = 9'(down_step_r[5:0] * `RCB_FIXED_STEP_MV);
	wire [14:0] gain_raw = 15'(dvs_step_mv * down_step_r[8:6]);
	wire [11:0] gain_mv  = 12'(gain_raw >> `RCB_GAIN_SHIFT);
	wire [11:0] start_mv = 12'({3'h0, fixed_mv} + gain_mv);

	rcb_step_return u_return (
		.mclk      (mclk),
		.rst       (rst),
		.load      (dvs_start && dvs_down),
		.load_mv   (start_mv),
		.rate_code (down_step_r[13:9]),
		.offset_mv (down_offset_mv)
	);

	// Undervoltage margins below reference
	logic [8:0] uv_lvl;
	always_comb begin
		unique case (uv_r[2:0])
			3'h0: uv_lvl = 9'h069;
			3'h1: uv_lvl = 9'h08d;
			3'h2: uv_lvl = 9'h0b2;
			3'h3: uv_lvl = 9'h0d6;
			3'h4: uv_lvl = 9'h0fc;
			3'h5: uv_lvl = 9'h123;
			3'h6: uv_lvl = 9'h148;
			3'h7: uv_lvl = 9'h192;
		endcase
		if (uv_r[3])
			uv_lvl = 9'h192;
	end

	assign uv_trip_margin_mv = uv_lvl;
	assign undervoltage_warning_margin_mv = uv_lvl - `RCB_UNDERVOLTAGE_WARNING_GAP_MV;
	assign uv_trip_hyst_mv   = `RCB_UV_TRIP_HYST_MV;
	assign undervoltage_warning_hyst_mv   = `RCB_UNDERVOLTAGE_WARNING_HYST_MV;

	// Persistence filter
	wire [11:0] uv_dly = (uv_r[5:4] == 2'h0) ? UV_DLY0 :
		(uv_r[5:4] == 2'h1) ? UV_DLY1 : (uv_r[5:4] == 2'h2) ? UV_DLY2 : UV_DLY3;
	wire uv_arm    = uv_raw && !prot_r[`RCB_PROT_UV_TRIP];
	wire uv_expire = uv_arm && !uv_trip_r && (uv_cnt_r >= uv_dly - 12'h001);
	assign uv_cnt_nxt = (!uv_arm || uv_trip_r) ? 12'h000 : uv_cnt_r + 12'h001;

	always_ff @(posedge mclk) begin
		if (rst) begin
			uv_cnt_r  <= 12'h000;
			uv_trip_r <= 1'b0;
			undervoltage_warning_r <= 1'b0;
			hiccup_r  <= 1'b0;
		end else begin
			uv_cnt_r  <= uv_cnt_nxt;
			uv_trip_r <= uv_arm && (uv_trip_r || uv_expire);
			undervoltage_warning_r <= undervoltage_warning_raw && !prot_r[`RCB_PROT_UNDERVOLTAGE_WARNING];
			hiccup_r  <= uv_expire && uv_r[6];
		end
	end

	assign uv_trip    = uv_trip_r;
	assign undervoltage_warning    = undervoltage_warning_r;
	assign hiccup_req = hiccup_r;

	// Power-state transition offsets
	wire from_light = ps_from == RCB_PS_LIGHT;
	wire to_light   = ps_to == RCB_PS_LIGHT;
	wire heavy_from = ps_from == RCB_PS_FULL || ps_from == RCB_PS_INTER;
	wire heavy_to   = ps_to == RCB_PS_FULL || ps_to == RCB_PS_INTER;
	assign ps_off_nxt = !ps_change ? ps_off_r :
		(from_light && heavy_to) ? rcb_mv20(pscomp_r[2:0]) :
		(heavy_from && to_light) ? rcb_mv20(pscomp_r[8:6]) :
		(ps_from == RCB_PS_INTER && ps_to == RCB_PS_FULL) ? rcb_mv20({1'b0, pscomp_r[10:9]}) :
		8'h00;

	always_ff @(posedge mclk) begin
		if (rst)
			ps_off_r <= 8'h00;
		else
			ps_off_r <= ps_off_nxt;
	end

	assign ps_offset_mv    = ps_off_r;
	assign comp_clamp_mv   = 7'((pscomp_r[4:3] + 3'h1) * `RCB_CLAMP_STEP_MV);
	assign decay_offset_mv = pscomp_r[5] ? `RCB_DECAY_HI_MV : `RCB_DECAY_LO_MV;

	// Transient tuning: dead band and decay per phase count
	wire [2:0] phase_fields;
	wire [1:0] speed_field;
	assign phase_fields = (phase_count <= 3'h1) ? mod_r[2:0] :
		(phase_count == 3'h2) ? mod_r[5:3] : mod_r[8:6];
	assign speed_field    = phase_fields[2:1];
	assign dead_band_fast = phase_fields[0];
	assign speedup_decay  = rcb_decay(speed_field);
	assign peak_cap_pf    = {1'b0, mod_r[10:9]} + 3'h1;
	assign hp_cap_pf      = {1'b0, mod_r[12:11]} + 3'h1;
	assign bal_gain_2x    = mod_r[13];
endmodule : rcb_bank

// ---- tb/rcb_nvm_model.sv ----
`timescale 1ns/10ps
module rcb_nvm_model #(
	parameter int GAP = 2
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        nvm_fetch_req,
	input  wire logic [2:0]  memory_bank_select_eff,
	output logic             nvm_ld,
	output logic      [7:0]  nvm_ld_code,
	output logic      [15:0] nvm_ld_data,
	output logic             nvm_ld_done
);
	logic [7:0] codes [5] = '{8'hd9, 8'hdf, 8'he1, 8'he2, 8'he3};
	int         idx = 0;
	int         wt = 0;
	initial begin
		nvm_ld_code = 8'h00;
		nvm_ld_data = 16'h0000;
	end
	always @(posedge mclk) begin
		if (rst || !nvm_fetch_req || nvm_ld_done) begin
			idx <= 0;
			wt <= 0;
			nvm_ld <= 1'h0;
			nvm_ld_done <= 1'h0;
			// Idle bus keeps moving so nothing stale is read
			nvm_ld_code <= ~nvm_ld_code;
			nvm_ld_data <= ~nvm_ld_data;
		end else if (wt < GAP) begin
			wt <= wt + 1;
			nvm_ld <= 1'h0;
		end else if (idx < 5) begin
			// Word tagged with bank so the source bank is visible
			nvm_ld <= 1'h1;
			nvm_ld_code <= codes[idx];
			nvm_ld_data <= {5'h00, memory_bank_select_eff, codes[idx]};
			idx <= idx + 1;
			wt <= 0;
		end else begin
			nvm_ld <= 1'h0;
			nvm_ld_done <= 1'h1;
		end
	end
endmodule : rcb_nvm_model

// ---- tb/rcb_checker.sv ----
`timescale 1ns/10ps
module rcb_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  cmd_code,
	input wire logic        cmd_wr,
	input wire logic        cmd_rd,
	input wire logic [15:0] cmd_wdata,
	input wire logic        cmd_rvalid,
	input wire logic        cmd_err,
	input wire logic        nvm_fetch_req,
	input wire logic        nvm_ld_done,
	input wire logic [7:0]  target_code,
	input wire logic [8:0]  prot_disable,
	input wire logic        uv_raw,
	input wire logic        undervoltage_warning_raw,
	input wire logic        uv_trip,
	input wire logic        undervoltage_warning,
	input wire logic        hiccup_req,
	input wire logic [7:0]  decay_offset_mv
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence wr_s(c);
		cmd_wr && cmd_code == c && !nvm_fetch_req;
	endsequence
	read_answer_a: assert property (cmd_rd |=> cmd_rvalid) else $error("read unanswered");
	target_write_a: assert property (wr_s(8'hda) |=> target_code == $past(cmd_wdata[7:0])) else $error("target");
	strap_ro_a: assert property (wr_s(8'hdc) |=> cmd_err) else $error("strap write taken");
	mask_write_a: assert property (wr_s(8'hdf) |=> prot_disable == $past(cmd_wdata[8:0])) else $error("mask");
	decay_sel_a: assert property (wr_s(8'he2) |=> decay_offset_mv == ($past(cmd_wdata[5]) ? 8'hc8 : 8'h64)) else $error("decay");
	uv_drop_a: assert property (!uv_raw |=> !uv_trip) else $error("trip held");
	warn_on_a: assert property (undervoltage_warning_raw && !prot_disable[8] |=> undervoltage_warning) else $error("warn lost");
	warn_mask_a: assert property (prot_disable[8] |=> !undervoltage_warning) else $error("warn unmasked");
	hiccup_rise_a: assert property (hiccup_req |-> $rose(uv_trip)) else $error("stray hiccup");
	fetch_end_a: assert property (nvm_fetch_req && nvm_ld_done |=> !nvm_fetch_req) else $error("fetch stuck");
endmodule : rcb_checker
bind rcb_bank rcb_checker rcb_checker_i (.*);

// ---- tb/rcb_bank_bench.sv ----
`timescale 1ns/10ps
module rcb_bank_bench import rcb_pkg::*;;
	logic        mclk = 1'h0, rst = 1'h1, cmd_wr = 1'h0, cmd_rd = 1'h0, dvs_start = 1'h0, dvs_down = 1'h1;
	logic        uv_raw = 1'h0, undervoltage_warning_raw = 1'h0, ps_change = 1'h0, cmd_rvalid, cmd_err, nvm_fetch_req;
	logic        nvm_ld, nvm_ld_done, uv_trip, undervoltage_warning, hiccup_req, dead_band_fast, bal_gain_2x;
	logic [1:0]  bank_overwritten = 2'h0, ps_from = 2'h0, ps_to = 2'h0, speedup_decay;
	logic [2:0]  bank_strap = 3'h3, phase_count = 3'h1, memory_bank_select_eff, peak_cap_pf, hp_cap_pf;
	logic [4:0]  strap_low = 5'h00;
	logic [6:0]  comp_clamp_mv;
	logic [7:0]  cmd_code = 8'h00, strap_high = 8'h00, nvm_ld_code, target_code, offset_code;
	logic [7:0]  ps_offset_mv, decay_offset_mv;
	logic [8:0]  prot_disable, uv_trip_margin_mv, undervoltage_warning_margin_mv, uv_trip_hyst_mv, undervoltage_warning_hyst_mv;
	logic [11:0] dvs_step_mv = 12'h000, down_offset_mv;
	logic [15:0] cmd_wdata = 16'h0000, cmd_rdata, nvm_ld_data, w;
	logic [7:0]  rwc [3] = '{8'hda, 8'hdb, 8'hdf};
	logic [3:0]  pst [6] = '{4'h8, 4'h9, 4'h2, 4'h6, 4'h4, 4'ha};
	int          uvm [8] = '{105, 141, 178, 214, 252, 291, 328, 402};
	int          dl [4] = '{250, 500, 1000, 3000};
	int          num_errors = 0, n_checks = 0, cyc = 0, n, e;
	rcb_bank rcb_bank_i (.*);
	rcb_nvm_model rcb_nvm_model_i (.*);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic er);
		@(posedge mclk);
		cmd_wr <= 1'h1;
		cmd_code <= c;
		cmd_wdata <= d;
		@(posedge mclk);
		cmd_wr <= 1'h0;
		#1 chk(cmd_err, er);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic er);
		@(posedge mclk);
		cmd_rd <= 1'h1;
		cmd_code <= c;
		@(posedge mclk);
		cmd_rd <= 1'h0;
		#1 chk({cmd_rvalid, cmd_err, cmd_rdata}, {1'h1, er, exp});
	endtask : rd
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial begin
		void'($urandom(54209));
		@(posedge mclk);
		strap_low <= $urandom;
		strap_high <= $urandom;
		repeat (15) @(posedge mclk);
		rst <= 1'h0;
		repeat (3) @(posedge mclk);
		while (nvm_fetch_req !== 1'h0) @(posedge mclk);
		#1 chk({memory_bank_select_eff, prot_disable}, {3'h3, 9'h1df});
		chk(uv_trip_margin_mv, 9'h08d);
		rd(8'hde, 16'h0003, 1'h0);
		rd(8'hda, 16'h0000, 1'h0);
		rd(8'hdb, 16'h0000, 1'h0);
		wr(8'hdc, 16'hffff, 1'h1);
		rd(8'hdc, {11'h000, strap_low}, 1'h0);
		wr(8'hdd, 16'hffff, 1'h1);
		rd(8'hdd, {8'h00, strap_high}, 1'h0);
		rd(8'he0, 16'h0000, 1'h1);
		for (int i = 0; i < 6; i++) begin
			w = $urandom;
			wr(rwc[i % 3], w, 1'h0);
			rd(rwc[i % 3], w & (i % 3 == 2 ? 16'h01ff : 16'h00ff), 1'h0);
			if (i % 3 == 1) chk(offset_code, w[7:0]);
		end
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			bank_overwritten <= i[3] ? 2'h3 : 2'h0;
			wr(8'hde, {13'h0000, i[2:0]}, 1'h0);
			n = i % 8;
			e = n < 5 ? n : n == 5 ? 6 : n == 6 ? (i[3] ? 6 : 0) : (i[3] ? 7 : 1);
			chk(memory_bank_select_eff, e);
		end
		for (int i = 0; i < 10; i++) begin
			wr(8'he1, i[15:0], 1'h0);
			n = uvm[i > 7 ? 7 : i];
			chk(uv_trip_margin_mv, n);
			chk(undervoltage_warning_margin_mv, n - 66);
			chk({uv_trip_hyst_mv, undervoltage_warning_hyst_mv}, {9'h013, 9'h011});
		end
		wr(8'hdf, 16'h0000, 1'h0);
		for (int d = 0; d < 4; d++) begin
			wr(8'he1, {9'h000, d[0], d[1:0], 4'h0}, 1'h0);
			@(posedge mclk);
			uv_raw <= 1'h1;
			undervoltage_warning_raw <= d[0];
			n = 0;
			do begin
				@(posedge mclk);
				#1 n++;
			end while (uv_trip !== 1'h1 && n < 3100);
			chk(n, dl[d]);
			chk(hiccup_req, d[0]);
			chk(undervoltage_warning, d[0]);
			@(posedge mclk);
			uv_raw <= 1'h0;
		end
		wr(8'he1, 16'h0040, 1'h0);
		wr(8'hdf, 16'h0120, 1'h0);
		@(posedge mclk);
		uv_raw <= 1'h1;
		repeat (300) @(posedge mclk);
		chk({uv_trip, undervoltage_warning}, 2'h0);
		uv_raw <= 1'h0;
		for (int r = 0; r < 3; r++) begin
			n = r == 2 ? 31 : r;
			w = {2'h0, n[4:0], 9'h000} | ($urandom % 63 + 1) | (($urandom % 8) << 6);
			wr(8'hd9, w, 1'h0);
			@(posedge mclk);
			dvs_step_mv <= $urandom;
			dvs_start <= 1'h1;
			@(posedge mclk);
			dvs_start <= 1'h0;
			e = w[5:0] * 5 + dvs_step_mv * w[8:6] / 32;
			#1 chk(down_offset_mv, e);
			repeat (4 * n + 3) @(posedge mclk);
			#1 chk(down_offset_mv, e);
			@(posedge mclk);
			#1 chk(down_offset_mv, e - 5);
		end
		w = $urandom;
		wr(8'he2, w, 1'h0);
		chk(comp_clamp_mv, (w[4:3] + 1) * 20);
		chk(decay_offset_mv, w[5] ? 8'hc8 : 8'h64);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			{ps_from, ps_to} <= pst[i];
			ps_change <= 1'h1;
			@(posedge mclk);
			ps_change <= 1'h0;
			e = i < 2 ? w[2:0] : i < 4 ? w[8:6] : i == 4 ? w[10:9] : 0;
			#1 chk(ps_offset_mv, e * 20);
		end
		w = $urandom;
		wr(8'he3, w, 1'h0);
		for (int p = 1; p < 4; p++) begin
			@(posedge mclk);
			phase_count <= p[2:0];
			n = w >> (p == 1 ? 0 : p == 2 ? 3 : 6);
			#1 chk(dead_band_fast, n[0]);
			chk(speedup_decay, n[2:1] == 2'h3 ? 2'h0 : n[2:1]);
			chk({peak_cap_pf, hp_cap_pf, bal_gain_2x}, {w[10:9] + 3'h1, w[12:11] + 3'h1, w[13]});
		end
		give_verdict();
	end
endmodule : rcb_bank_bench
